// file: inc/fbx_pkg.sv
// package: register codes, reset values, bus constants and pin carrier for the four-bit expander
package fbx_pkg;
    // ==========================================================
    // register command codes
    localparam logic [7:0] CMD_PIN_LEVEL_IN     = 8'h00;
    localparam logic [7:0] CMD_DRIVE_LATCH      = 8'h01;
    localparam logic [7:0] CMD_INVERT_SELECT    = 8'h02;
    localparam logic [7:0] CMD_DIRECTION_SELECT = 8'h03;
    // ==========================================================
    // reset values and field layout
    localparam logic [7:0] RST_DRIVE_LATCH      = 8'hff;
    localparam logic [7:0] RST_INVERT_SELECT    = 8'h00;
    localparam logic [7:0] RST_DIRECTION_SELECT = 8'hff;
    localparam logic [3:0] PIN_LEVEL_UPPER      = 4'hf;
    localparam logic [7:0] UNMAPPED_READ        = 8'hff;
    localparam int         PIN_COUNT            = 4;
    // ==========================================================
    // bus constants
    localparam logic [6:0] TARGET_ADDRESS       = 7'h49;
    localparam logic [6:0] GENERAL_CALL_ADDRESS = 7'h00;
    localparam logic [7:0] SOFT_RESET_BYTE      = 8'h06;
    // ==========================================================
    // pin carrier
    typedef struct packed {
        logic [3:0] drive;
        logic [3:0] enable_n;
    } fbx_pin_out_type;
endpackage

// file: logic/fbx_expander.sv
// four-bit i2c io expander: serial target, register file and pin datapath
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
module fbx_expander
(
    input  wire logic                     clock,
    input  wire logic                     reset,
    input  wire logic                     scl_in,
    input  wire logic                     sda_in,
    output logic                          sda_out,
    output logic                          sda_oe_n,
    input  wire logic [3:0]               expander_pin_in,
    output fbx_pkg::fbx_pin_out_type      expander_pin_out
);
    import fbx_pkg::*;

    // ==========================================================
    // input synchronisers
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [3:0] pin_meta;
    logic [3:0] pin_level_bit;
    logic       scl_prev;
    logic       sda_prev;

    always_ff @(posedge clock)
    begin
        scl_sync <= {scl_sync[0], scl_in};
        sda_sync <= {sda_sync[0], sda_in};
        pin_meta <= expander_pin_in;
        pin_level_bit <= pin_meta;
        scl_prev <= scl_sync[1];
        sda_prev <= sda_sync[1];
    end

    wire logic scl = scl_sync[1];
    wire logic sda = sda_sync[1];
    wire logic scl_rise = scl & ~scl_prev;
    wire logic scl_fall = ~scl & scl_prev;
    wire logic start_seen = scl & scl_prev & sda_prev & ~sda;
    wire logic stop_seen  = scl & scl_prev & ~sda_prev & sda;

    // ==========================================================
    // registers
    logic [7:0] pointer;
    logic [3:0] drive_latch_bit;
    logic [3:0] invert_select_bit;
    logic [3:0] direction_bit;
    logic       soft_reset;

    // inversion only on input pins; output pins report raw level
    function automatic logic [7:0] read_mux(input logic [7:0] cmd, input logic [3:0] lvl,
                                            input logic [3:0] drv, input logic [3:0] inv,
                                            input logic [3:0] dir);
        unique case (cmd)
            CMD_PIN_LEVEL_IN:     read_mux = {PIN_LEVEL_UPPER, lvl ^ (inv & dir)};
            CMD_DRIVE_LATCH:      read_mux = {RST_DRIVE_LATCH[7:4], drv};
            CMD_INVERT_SELECT:    read_mux = {RST_INVERT_SELECT[7:4], inv};
            CMD_DIRECTION_SELECT: read_mux = {RST_DIRECTION_SELECT[7:4], dir};
            default:              read_mux = UNMAPPED_READ;
        endcase
    endfunction

    // ==========================================================
    // serial target state machine
    typedef enum logic [2:0]
    {
        ST_IDLE     = 3'b000,
        ST_ADDR     = 3'b001,
        ST_ADDR_ACK = 3'b011,
        ST_WBYTE    = 3'b010,
        ST_WACK     = 3'b110,
        ST_RBYTE    = 3'b111,
        ST_RACK     = 3'b101
    } fbx_state_type;

    fbx_state_type state;
    logic [7:0]    shift;
    logic [3:0]    bit_count;
    logic          is_read;
    logic          is_gcall;
    logic          first_byte;
    logic          gcall_armed;
    logic          ack_drive;
    logic          data_drive;
    logic          wbyte_count_zero;

    wire logic addr_match = (shift[7:1] == TARGET_ADDRESS);
    wire logic gcall_match = (shift[7:1] == GENERAL_CALL_ADDRESS) & ~shift[0];
    // a general call may carry only one byte, and only 0x06 is acknowledged
    wire logic byte_ok = is_gcall ? (wbyte_count_zero & (shift == SOFT_RESET_BYTE)) : 1'b1;
    // read byte for the current pointer; bit 7 leaves first
    wire logic [7:0] read_value = read_mux(pointer, pin_level_bit, drive_latch_bit,
                                           invert_select_bit, direction_bit);

    always_ff @(posedge clock)
    begin
        if (reset || soft_reset)
        begin
            state <= ST_IDLE;
            shift <= 8'h00;
            bit_count <= 4'h0;
            is_read <= 1'b0;
            is_gcall <= 1'b0;
            first_byte <= 1'b0;
            gcall_armed <= 1'b0;
            ack_drive <= 1'b0;
            data_drive <= 1'b1;
            wbyte_count_zero <= 1'b1;
        end
        else if (start_seen)
        begin
            state <= ST_ADDR;
            bit_count <= 4'h0;
            gcall_armed <= 1'b0;
            ack_drive <= 1'b0;
            data_drive <= 1'b1;
        end
        else if (stop_seen)
        begin
            state <= ST_IDLE;
            ack_drive <= 1'b0;
            data_drive <= 1'b1;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                    ;
                ST_ADDR, ST_WBYTE:
                    if (scl_rise)
                    begin
                        shift <= {shift[6:0], sda};
                        bit_count <= bit_count + 4'h1;
                    end
                    else if (scl_fall && bit_count == 4'h8)
                    begin
                        bit_count <= 4'h0;
                        if (state == ST_ADDR)
                        begin
                            if (addr_match || gcall_match)
                            begin
                                state <= ST_ADDR_ACK;
                                ack_drive <= 1'b1;
                                is_read <= shift[0];
                                is_gcall <= gcall_match;
                                first_byte <= 1'b1;
                                wbyte_count_zero <= 1'b1;
                            end
                            else
                                state <= ST_IDLE;
                        end
                        else if (byte_ok)
                        begin
                            state <= ST_WACK;
                            ack_drive <= 1'b1;
                        end
                        else
                        begin
                            state <= ST_IDLE;
                            gcall_armed <= 1'b0;
                        end
                    end
                ST_ADDR_ACK, ST_WACK:
                    if (scl_fall)
                    begin
                        ack_drive <= 1'b0;
                        if (is_read)
                        begin
                            state <= ST_RBYTE;
                            shift <= read_value;
                            data_drive <= read_value[7];
                        end
                        else
                            state <= ST_WBYTE;
                        if (state == ST_WACK)
                        begin
                            first_byte <= 1'b0;
                            wbyte_count_zero <= 1'b0;
                            gcall_armed <= is_gcall & wbyte_count_zero;
                        end
                    end
                ST_RBYTE:
                    if (scl_fall)
                    begin
                        if (bit_count == 4'h7)
                        begin
                            state <= ST_RACK;
                            data_drive <= 1'b1;
                            bit_count <= 4'h0;
                        end
                        else
                        begin
                            shift <= {shift[6:0], 1'b0};
                            data_drive <= shift[6];
                            bit_count <= bit_count + 4'h1;
                        end
                    end
                ST_RACK:
                    if (scl_rise)
                        state <= sda ? ST_IDLE : ST_ADDR_ACK;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // write strobe at the acknowledge clock's rising edge
    wire logic write_strobe = (state == ST_WACK) & scl_rise & ~is_gcall & ~is_read;

    // ==========================================================
    // soft reset: armed by one good general-call byte, fired only by stop
    always_ff @(posedge clock)
    begin
        if (reset)
            soft_reset <= 1'b0;
        else
            // the stop's own scl rise lands in the next bit slot, so exactly one bit is counted
            soft_reset <= stop_seen & gcall_armed & (state == ST_WBYTE) & (bit_count == 4'h1);
    end

    // ==========================================================
    // pointer and register file
    always_ff @(posedge clock)
    begin
        if (reset || soft_reset)
            pointer <= CMD_PIN_LEVEL_IN;
        else if (write_strobe && first_byte)
            pointer <= shift;
    end

    always_ff @(posedge clock)
    begin
        if (reset || soft_reset)
        begin
            drive_latch_bit <= RST_DRIVE_LATCH[3:0];
            invert_select_bit <= RST_INVERT_SELECT[3:0];
            direction_bit <= RST_DIRECTION_SELECT[3:0];
        end
        else if (write_strobe && !first_byte)
        begin
            // only low nibble stored; input register and unmapped codes fall through
            unique case (pointer)
                CMD_DRIVE_LATCH:      drive_latch_bit <= shift[3:0];
                CMD_INVERT_SELECT:    invert_select_bit <= shift[3:0];
                CMD_DIRECTION_SELECT: direction_bit <= shift[3:0];
                default:              ;
            endcase
        end
    end

    // ==========================================================
    // pin and bus drivers; enables active low, one means released
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            expander_pin_out <= '{drive: 4'hf, enable_n: 4'hf};
            sda_oe_n <= 1'b1;
        end
        else
        begin
            expander_pin_out.drive <= drive_latch_bit;
            expander_pin_out.enable_n <= direction_bit;
            sda_oe_n <= ~(ack_drive | (state == ST_RBYTE & ~data_drive));
        end
    end

    assign sda_out = 1'b0;

    // ==========================================================
    // checks
    property p_dir_drive;
        @(posedge clock) disable iff (reset)
        ##1 expander_pin_out.enable_n == $past(direction_bit);
    endproperty
    a_dir_drive: assert property (p_dir_drive) else $error("pin enable mismatch");

    property p_ro_input;
        @(posedge clock) disable iff (reset)
        (write_strobe && !first_byte && pointer == CMD_PIN_LEVEL_IN) |=> $stable({drive_latch_bit,
            invert_select_bit, direction_bit});
    endproperty
    a_ro_input: assert property (p_ro_input) else $error("input register write stored");

    property p_reset_vals;
        @(posedge clock) reset |=> (drive_latch_bit == 4'hf && direction_bit == 4'hf && invert_select_bit == 4'h0);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

    property p_pointer_hold;
        @(posedge clock) disable iff (reset)
        !(write_strobe && first_byte) && !soft_reset |=> $stable(pointer);
    endproperty
    a_pointer_hold: assert property (p_pointer_hold) else $error("pointer moved");

    property p_drive_follow;
        @(posedge clock) disable iff (reset)
        ##1 expander_pin_out.drive == $past(drive_latch_bit);
    endproperty
    a_drive_follow: assert property (p_drive_follow) else $error("pin drive mismatch");

    property p_soft_defaults;
        @(posedge clock) disable iff (reset)
        soft_reset |=> (pointer == CMD_PIN_LEVEL_IN && state == ST_IDLE && drive_latch_bit == RST_DRIVE_LATCH[3:0]
            && invert_select_bit == RST_INVERT_SELECT[3:0] && direction_bit == RST_DIRECTION_SELECT[3:0]);
    endproperty
    a_soft_defaults: assert property (p_soft_defaults) else $error("soft reset left state behind");

    property p_unmapped_write;
        @(posedge clock) disable iff (reset)
        (write_strobe && !first_byte && pointer > CMD_DIRECTION_SELECT) |=> $stable({drive_latch_bit,
            invert_select_bit, direction_bit});
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write stored");

    property p_foreign_addr;
        @(posedge clock) disable iff (reset)
        (state == ST_ADDR && scl_fall && bit_count == 4'h8 && !addr_match && !gcall_match) |=> (state == ST_IDLE
            && !ack_drive);
    endproperty
    a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address taken");
endmodule
`default_nettype wire

// file: verification/fbx_i2c_controller.sv
// i2c bus controller model that drives the expander's serial port
`timescale 1ns/1ps
`default_nettype none
module fbx_i2c_controller
    import fbx_pkg::*;
#(
    parameter int HALF = 10
)
(
    input  wire logic clock,
    output logic      scl,
    output logic      sda_drive,
    input  wire logic sda_line
);
    // ==========================================================
    // bus primitives; lines change only after a falling clock edge
    initial
    begin
        scl = 1'b1;
        sda_drive = 1'b1;
    end
    task automatic wait_half();
        repeat (HALF) @(negedge clock);
    endtask
    // serves as repeated start too, since scl is raised with sda released
    task automatic bus_start();
        sda_drive = 1'b1;
        wait_half();
        scl = 1'b1;
        wait_half();
        sda_drive = 1'b0;
        wait_half();
        scl = 1'b0;
        wait_half();
    endtask
    task automatic bus_stop();
        sda_drive = 1'b0;
        wait_half();
        scl = 1'b1;
        wait_half();
        sda_drive = 1'b1;
        wait_half();
    endtask
    // sda moves two cycles after scl falls so the synchronisers never see both change together
    task automatic clock_bit(input logic value, output logic seen);
        sda_drive = value;
        wait_half();
        scl = 1'b1;
        repeat (HALF / 2) @(negedge clock);
        seen = sda_line;
        repeat (HALF - HALF / 2) @(negedge clock);
        scl = 1'b0;
        repeat (2) @(negedge clock);
    endtask
    task automatic xfer_byte(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx, output logic ack_in);
        for (int i = 7; i >= 0; i--)
            clock_bit(tx[i], rx[i]);
        clock_bit(ack_out, ack_in);
    endtask
    // ==========================================================
    // whole transfers; nacks holds address, first and second byte
    task automatic write_frame(input logic [6:0] addr, input logic [7:0] b1, input logic [7:0] b2,
                               input int count, output logic [2:0] nacks);
        logic [7:0] unused;
        nacks = 3'b000;
        bus_start();
        xfer_byte({addr, 1'b0}, 1'b1, unused, nacks[0]);
        if (count > 0)
            xfer_byte(b1, 1'b1, unused, nacks[1]);
        if (count > 1)
            xfer_byte(b2, 1'b1, unused, nacks[2]);
        bus_stop();
    endtask
    // a read never carries a command byte; the last byte is refused to end it
    task automatic read_frame(output logic [7:0] d0, output logic [7:0] d1);
        logic [7:0] unused;
        logic       ack;
        bus_start();
        xfer_byte({TARGET_ADDRESS, 1'b1}, 1'b1, unused, ack);
        xfer_byte(8'hff, 1'b0, d0, ack);
        xfer_byte(8'hff, 1'b1, d1, ack);
        bus_stop();
    endtask
endmodule
`default_nettype wire

// file: verification/fbx_expander_bench.sv
// self-checking bench for the four-bit expander
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); \
            err_count++; \
        end \
    end
module fbx_expander_bench;
    import fbx_pkg::*;
    logic            clock;
    logic            reset;
    logic [3:0]      ext_pins;
    logic [3:0]      pin_in;
    fbx_pin_out_type pin_out;
    logic            scl;
    logic            sda_drive;
    logic            sda_out;
    logic            sda_oe_n;
    wire logic       sda_line;
    int              err_count;
    int              compares;
    // released sda floats to the pull-up level
    assign sda_line = sda_drive & (sda_oe_n | sda_out);
    // driven pins show the latch, the rest the outside level
    assign pin_in = (pin_out.enable_n & ext_pins) | (~pin_out.enable_n & pin_out.drive);
    fbx_expander dut
    (
        .clock            (clock),
        .reset            (reset),
        .scl_in           (scl),
        .sda_in           (sda_line),
        .sda_out          (sda_out),
        .sda_oe_n         (sda_oe_n),
        .expander_pin_in  (pin_in),
        .expander_pin_out (pin_out)
    );
    fbx_i2c_controller ctl
    (
        .clock     (clock),
        .scl       (scl),
        .sda_drive (sda_drive),
        .sda_line  (sda_line)
    );
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ==========================================================
    // shared tasks
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic expect_reg(input logic [7:0] cmd, input logic [7:0] exp);
        logic [2:0] nacks;
        logic [7:0] d0;
        logic [7:0] d1;
        ctl.write_frame(TARGET_ADDRESS, cmd, 8'h00, 1, nacks);
        ctl.read_frame(d0, d1);
        `CHECK(nacks, 3'b000)
        `CHECK(d0, exp)
        `CHECK(d1, exp)
    endtask
    task automatic write_reg(input logic [7:0] cmd, input logic [7:0] data);
        logic [2:0] nacks;
        ctl.write_frame(TARGET_ADDRESS, cmd, data, 2, nacks);
        `CHECK(nacks, 3'b000)
    endtask
    // ==========================================================
    // scenarios
    task automatic test_reset_values();
        `CHECK(pin_out, {4'hf, 4'hf})
        expect_reg(CMD_DRIVE_LATCH, RST_DRIVE_LATCH);
        expect_reg(CMD_INVERT_SELECT, RST_INVERT_SELECT);
        expect_reg(CMD_DIRECTION_SELECT, RST_DIRECTION_SELECT);
        $display("test reset values done");
    endtask
    task automatic test_pin_path();
        expect_reg(CMD_PIN_LEVEL_IN, 8'hfa);
        write_reg(CMD_INVERT_SELECT, 8'hf3);
        expect_reg(CMD_INVERT_SELECT, 8'h03);
        expect_reg(CMD_PIN_LEVEL_IN, 8'hf9);
        write_reg(CMD_DRIVE_LATCH, 8'h06);
        write_reg(CMD_DIRECTION_SELECT, 8'h05);
        `CHECK(pin_out, {4'h6, 4'h5})
        expect_reg(CMD_DIRECTION_SELECT, 8'hf5);
        expect_reg(CMD_DRIVE_LATCH, 8'hf6);
        expect_reg(CMD_PIN_LEVEL_IN, 8'hf3);
        $display("test pin path done");
    endtask
    task automatic test_refused();
        logic [2:0] nacks;
        logic [7:0] d0;
        logic [7:0] d1;
        write_reg(CMD_PIN_LEVEL_IN, 8'h00);
        expect_reg(CMD_DRIVE_LATCH, 8'hf6);
        write_reg(8'h07, 8'h00);
        ctl.read_frame(d0, d1);
        `CHECK(d0, UNMAPPED_READ)
        expect_reg(CMD_DIRECTION_SELECT, 8'hf5);
        ctl.write_frame(7'h4a, CMD_DRIVE_LATCH, 8'h00, 2, nacks);
        `CHECK(nacks, 3'b111)
        expect_reg(CMD_DRIVE_LATCH, 8'hf6);
        $display("test refused accesses done");
    endtask
    task automatic test_soft_reset();
        logic [2:0] nacks;
        logic [7:0] d0;
        logic [7:0] d1;
        ctl.write_frame(GENERAL_CALL_ADDRESS, 8'h07, 8'h00, 1, nacks);
        `CHECK(nacks, 3'b010)
        ctl.write_frame(GENERAL_CALL_ADDRESS, SOFT_RESET_BYTE, SOFT_RESET_BYTE, 2, nacks);
        `CHECK(nacks, 3'b100)
        expect_reg(CMD_DIRECTION_SELECT, 8'hf5);
        ctl.write_frame(GENERAL_CALL_ADDRESS, SOFT_RESET_BYTE, 8'h00, 1, nacks);
        `CHECK(nacks, 3'b000)
        ctl.read_frame(d0, d1);
        `CHECK(d0, 8'hfa)
        `CHECK(pin_out, {4'hf, 4'hf})
        expect_reg(CMD_DRIVE_LATCH, RST_DRIVE_LATCH);
        expect_reg(CMD_INVERT_SELECT, RST_INVERT_SELECT);
        $display("test soft reset done");
    endtask
    // ==========================================================
    // main sequence and hang guard
    initial
    begin
        err_count = 0;
        compares = 0;
        reset = 1'b1;
        ext_pins = 4'ha;
        repeat (5) @(negedge clock);
        reset = 1'b0;
        repeat (6) @(negedge clock);
        test_reset_values();
        test_pin_path();
        test_refused();
        test_soft_reset();
        finish_test();
    end
    initial
    begin
        repeat (80000) @(posedge clock);
        $display("wrong value at %0t ns: run did not finish", $time);
        err_count++;
        finish_test();
    end
endmodule
`undef CHECK
`default_nettype wire
